// file: bpz_ports.sv
// Two 8-bit bidirectional ports with mode, config and wake logic
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module bpz_ports #(
  parameter logic [1:0] P0_PU_OPT = 2'b00, // Build option: pull-up per nibble
  parameter logic       P2_PU_OPT = 1'b0   // Build option: pull-ups on all
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  input  wire logic        stop_mode_recovery,
  input  wire logic [11:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output var  logic [7:0]  bus_rdata,
  input  wire logic [7:0]  first_port_lines_i,
  output var  logic [7:0]  first_port_lines_o,
  output var  logic [7:0]  first_port_lines_oe,
  output var  logic [7:0]  first_port_pullup,
  input  wire logic [7:0]  second_port_lines_i,
  output var  logic [7:0]  second_port_lines_o,
  output var  logic [7:0]  second_port_lines_oe,
  output var  logic [7:0]  second_port_pullup,
  output var  logic        wake_and,
  output var  logic        wake_or,
  output var  logic        edge_detect_in
);
  typedef struct packed {
    logic [7:0] port0_1_mode_reg;
    logic [7:0] port2_mode_reg;
    logic [7:0] port_config_reg;
    logic [7:0] wake_ctrl;
    logic [7:0] p0_data;
    logic [7:0] p2_data;
    logic [7:0] rdata;
    logic       wake_and_q;
    logic       wake_or_q;
    logic       edge_in;
    logic       por_s1;
    logic       por_s2;
    logic       stop_s1;
    logic       stop_s2;
  } bpz_st_t;

  bpz_st_t                st_reg;
  bpz_st_t                st_next;
  logic [7:0]             p0_in;
  logic [7:0]             p2_in;
  logic [7:0]             p0_dir_out;
  logic [7:0]             p2_dir_out;
  logic [7:0]             p0_pu;
  logic [7:0]             p2_pu;
  bpz_pkg::bpz_pin_drv_t  p0_drv;
  bpz_pkg::bpz_pin_drv_t  p2_drv;

  // Pin inputs synchronised
  bpz_sync u_sync_p0 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (first_port_lines_i),
    .q     (p0_in)
  );
  bpz_sync u_sync_p2 (
    .mclk  (mclk),
    .rst_n (rst_n),
    .d     (second_port_lines_i),
    .q     (p2_in)
  );

  // Direction decode: first port per nibble, second per bit
  always_comb begin
    p0_dir_out = {{4{~st_reg.port0_1_mode_reg[bpz_pkg::MODE01_HI_NIB]}},
                  {4{~st_reg.port0_1_mode_reg[bpz_pkg::MODE01_LO_NIB]}}};
    p2_dir_out = ~st_reg.port2_mode_reg;
    p0_pu      = {{4{P0_PU_OPT[1]}}, {4{P0_PU_OPT[0]}}};
    p2_pu      = {8{P2_PU_OPT}};
  end

  // Next state: bus writes, resets from POR and stop recovery, wake gates
  always_comb begin
    st_next        = st_reg;
    st_next.por_s1 = por_n;
    st_next.por_s2 = st_reg.por_s1;
    st_next.stop_s1 = stop_mode_recovery;
    st_next.stop_s2 = st_reg.stop_s1;
    st_next.rdata  = 8'h00;
    if (bus_wr) begin
      case (bus_addr)
        bpz_pkg::ADDR_PORT01_MODE: st_next.port0_1_mode_reg = bus_wdata;
        bpz_pkg::ADDR_PORT2_MODE:  st_next.port2_mode_reg   = bus_wdata;
        bpz_pkg::ADDR_PORT_CONFIG: st_next.port_config_reg  = bus_wdata;
        bpz_pkg::ADDR_WAKE_CTRL:   st_next.wake_ctrl        = bus_wdata;
        bpz_pkg::ADDR_PORT0_DATA:  st_next.p0_data          = bus_wdata;
        bpz_pkg::ADDR_PORT2_DATA:  st_next.p2_data          = bus_wdata;
        default:                   st_next.rdata            = 8'h00;
      endcase
    end
    // Mode and config registers are write-only and read as zero
    if (bus_rd) begin
      case (bus_addr)
        bpz_pkg::ADDR_PORT0_DATA: st_next.rdata = p0_in;
        bpz_pkg::ADDR_PORT2_DATA: st_next.rdata = p2_in;
        bpz_pkg::ADDR_WAKE_CTRL:  st_next.rdata = st_reg.wake_ctrl;
        default:                  st_next.rdata = 8'h00;
      endcase
    end
    // Stop recovery returns first port groups to input
    if (st_reg.stop_s2) begin
      st_next.port0_1_mode_reg[bpz_pkg::MODE01_LO_NIB] = 1'b1;
      st_next.port0_1_mode_reg[bpz_pkg::MODE01_HI_NIB] = 1'b1;
    end
    // Power-on reset: both ports to input
    if (!st_reg.por_s2) begin
      st_next.port0_1_mode_reg = bpz_pkg::MODE01_RESET;
      st_next.port2_mode_reg   = bpz_pkg::MODE2_RESET;
    end
    st_next.wake_and_q = &p2_in;
    st_next.wake_or_q  = |p2_in;
    st_next.edge_in = st_reg.wake_ctrl[bpz_pkg::WAKE_DEMOD]
                      & st_reg.wake_ctrl[bpz_pkg::WAKE_EDGE_SEL] & p2_in[0];
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg                  <= '0;
      st_reg.port0_1_mode_reg <= bpz_pkg::MODE01_RESET;
      st_reg.port2_mode_reg   <= bpz_pkg::MODE2_RESET;
      st_reg.port_config_reg  <= bpz_pkg::CFG_RESET;
      st_reg.wake_ctrl        <= bpz_pkg::WAKE_RESET;
      st_reg.p0_data          <= bpz_pkg::DATA_RESET;
      st_reg.p2_data          <= bpz_pkg::DATA_RESET;
      st_reg.por_s1           <= 1'b1;
      st_reg.por_s2           <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pad drivers
  bpz_pad_drv u_pad_p0 (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .dir_out (p0_dir_out),
    .data    (st_reg.p0_data),
    .odrain  (st_reg.port_config_reg[bpz_pkg::CFG_P0_ODRN]),
    .pu_opt  (p0_pu),
    .drv     (p0_drv)
  );
  bpz_pad_drv u_pad_p2 (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .dir_out (p2_dir_out),
    .data    (st_reg.p2_data),
    .odrain  (st_reg.wake_ctrl[bpz_pkg::WAKE_P2_ODRN]),
    .pu_opt  (p2_pu),
    .drv     (p2_drv)
  );

  // Outputs from flops
  assign bus_rdata            = st_reg.rdata;
  assign first_port_lines_o   = p0_drv.dout;
  assign first_port_lines_oe  = p0_drv.oe;
  assign first_port_pullup    = p0_drv.pull_on;
  assign second_port_lines_o  = p2_drv.dout;
  assign second_port_lines_oe = p2_drv.oe;
  assign second_port_pullup   = p2_drv.pull_on;
  assign wake_and             = st_reg.wake_and_q;
  assign wake_or              = st_reg.wake_or_q;
  assign edge_detect_in       = st_reg.edge_in;

  // Checks on register decode, pad drive and wake logic

  // First port direction never splits inside a nibble
  a_p0_nibble_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    p0_dir_out[3:0] == {4{p0_dir_out[0]}} && p0_dir_out[7:4] == {4{p0_dir_out[4]}})
    else $error("first port nibble direction split");

  // First port output level follows its data register
  a_p0_dout: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> first_port_lines_o == $past(st_reg.p0_data))
    else $error("first port output level wrong");

  // Open drain never drives a one on first port line zero
  a_p0_odrain: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.port_config_reg[bpz_pkg::CFG_P0_ODRN] && p0_dir_out[0] && st_reg.p0_data[0])
    |=> !first_port_lines_oe[0])
    else $error("open drain drove high");

  // Push-pull drives every output line
  a_p0_pushpull: assert property (@(posedge mclk) disable iff (!rst_n)
    (!st_reg.port_config_reg[bpz_pkg::CFG_P0_ODRN] && p0_dir_out == 8'hFF)
    |=> first_port_lines_oe == 8'hFF)
    else $error("push-pull output not driven");

  // Low nibble mode write takes effect next cycle
  a_p0_mode_wr: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_wr && bus_addr == bpz_pkg::ADDR_PORT01_MODE && !bus_wdata[bpz_pkg::MODE01_LO_NIB]
     && !st_reg.stop_s2 && st_reg.por_s2) |=> p0_dir_out[0])
    else $error("mode write not taken");

  // High nibble mode write takes effect next cycle
  a_p0_hi_dir: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_wr && bus_addr == bpz_pkg::ADDR_PORT01_MODE && !bus_wdata[bpz_pkg::MODE01_HI_NIB]
     && !st_reg.stop_s2 && st_reg.por_s2) |=> p0_dir_out[4])
    else $error("high nibble mode write not taken");

  // First port direction moves only on a mode write or a forced input
  a_p0_mode_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (!bus_wr && !st_reg.stop_s2 && st_reg.por_s2) |=> $stable(p0_dir_out))
    else $error("first port direction changed without write");

  // Pull-up off wherever a first port pin is driven
  a_pullup_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (first_port_pullup & first_port_lines_oe) == 8'h00)
    else $error("pull-up on while driving");

  // Pull-up off wherever a second port pin is driven
  a_p2_pullup_off: assert property (@(posedge mclk) disable iff (!rst_n)
    (second_port_pullup & second_port_lines_oe) == 8'h00)
    else $error("second port pull-up on while driving");

  // Stop recovery forces first port input
  a_stop_input: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.stop_s2 |=> p0_dir_out == 8'h00)
    else $error("stop recovery left output");

  // First port pull-ups switch per nibble
  a_p0_pu_group: assert property (@(posedge mclk) disable iff (!rst_n)
    first_port_pullup[3:0] == {4{first_port_pullup[0]}}
    && first_port_pullup[7:4] == {4{first_port_pullup[4]}})
    else $error("first port pull-up split in nibble");

  // Second port direction follows its mode bits
  a_p2_bitdir: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_wr && bus_addr == bpz_pkg::ADDR_PORT2_MODE && st_reg.por_s2)
    |=> p2_dir_out == ~$past(bus_wdata))
    else $error("second port direction wrong");

  // Second port direction moves only on a mode write or power-on reset
  a_p2_mode_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    (!bus_wr && st_reg.por_s2) |=> $stable(p2_dir_out))
    else $error("second port direction changed without write");

  // Second port data register always writable
  a_p2_data_wr: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_wr && bus_addr == bpz_pkg::ADDR_PORT2_DATA) |=> st_reg.p2_data == $past(bus_wdata))
    else $error("second port data write lost");

  // Second port output level follows its data register
  a_p2_dout: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> second_port_lines_o == $past(st_reg.p2_data))
    else $error("second port output level wrong");

  // Second port pin read returns synchronised levels
  a_rd_pins: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_rd && bus_addr == bpz_pkg::ADDR_PORT2_DATA) |=> bus_rdata == $past(p2_in))
    else $error("second port read wrong");

  // All second port pull-ups follow the option when every line is input
  a_p2_pu_all: assert property (@(posedge mclk) disable iff (!rst_n)
    (p2_dir_out == 8'h00) |=> second_port_pullup == {8{P2_PU_OPT}})
    else $error("second port pull-up option not applied");

  // Open drain on second port never drives a one
  a_p2_odrain: assert property (@(posedge mclk) disable iff (!rst_n)
    st_reg.wake_ctrl[bpz_pkg::WAKE_P2_ODRN]
    |=> (second_port_lines_oe & $past(st_reg.p2_data)) == 8'h00)
    else $error("second port open drain drove high");

  // Push-pull on second port drives every output line
  a_p2_shared_type: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_reg.wake_ctrl[bpz_pkg::WAKE_P2_ODRN] |=> second_port_lines_oe == $past(p2_dir_out))
    else $error("second port push-pull line not driven");

  // Power-on reset forces both ports input
  a_por_input: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_reg.por_s2 |=> p2_dir_out == 8'h00 && p0_dir_out == 8'h00)
    else $error("POR left output");

  // Wake gates follow the synchronised pins
  a_wake_gates: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 wake_and == &$past(p2_in) && wake_or == |$past(p2_in))
    else $error("wake gate mismatch");

  // No edge tap outside demodulation
  a_edge_tap: assert property (@(posedge mclk) disable iff (!rst_n)
    !st_reg.wake_ctrl[bpz_pkg::WAKE_DEMOD] |=> !edge_detect_in)
    else $error("edge tap outside demodulation");

  // Bit zero reaches the edge tap when selected in demodulation
  a_edge_on: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_reg.wake_ctrl[bpz_pkg::WAKE_DEMOD] && st_reg.wake_ctrl[bpz_pkg::WAKE_EDGE_SEL] && p2_in[0])
    |=> edge_detect_in)
    else $error("edge tap not fed in demodulation");

  // Write-only registers read as zero
  a_wo_read_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    (bus_rd && (bus_addr == bpz_pkg::ADDR_PORT2_MODE || bus_addr == bpz_pkg::ADDR_PORT01_MODE
     || bus_addr == bpz_pkg::ADDR_PORT_CONFIG)) |=> bus_rdata == 8'h00)
    else $error("write-only register readable");
endmodule
`default_nettype wire

// file: bpz_pkg.sv
// Package of constants and types for the two bidirectional ports
package bpz_pkg;
  // Register addresses; bank F offsets carry bank in upper nibble
  localparam logic [11:0] ADDR_PORT2_MODE   = 12'h0F6;
  localparam logic [11:0] ADDR_PORT01_MODE  = 12'h0F8;
  localparam logic [11:0] ADDR_PORT_CONFIG  = 12'hF00;
  localparam logic [11:0] ADDR_PORT0_DATA   = 12'h000;
  localparam logic [11:0] ADDR_PORT2_DATA   = 12'h002;
  localparam logic [11:0] ADDR_WAKE_CTRL    = 12'hF01;
  // Field positions
  localparam int MODE01_LO_NIB = 1;   // 1 = input for low nibble
  localparam int MODE01_HI_NIB = 6;   // 1 = input for high nibble
  localparam int CFG_P0_ODRN   = 2;   // 1 = open drain on first port
  localparam int WAKE_P2_ODRN  = 0;   // 1 = open drain on second port
  localparam int WAKE_DEMOD    = 1;   // Demodulation mode select
  localparam int WAKE_EDGE_SEL = 2;   // Bit zero routed to edge detect
  // Reset values
  localparam logic [7:0] MODE01_RESET = 8'hCF;
  localparam logic [7:0] MODE2_RESET  = 8'hFF;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Pin triple of an 8-bit two-way port
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull_on;
  } bpz_pin_drv_t;

  // Register bus request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bpz_bus_req_t;

  // Drive an 8-bit port: push-pull drives both levels, open drain only low
  function automatic logic [7:0] drive_oe(input logic [7:0] dir_out,
                                          input logic [7:0] data,
                                          input logic       odrain);
    drive_oe = odrain ? (dir_out & ~data) : dir_out;
  endfunction
endpackage

// file: bpz_sync.sv
// Two-flop synchroniser for an 8-bit pin group
`timescale 1ns/1ps
`default_nettype none
module bpz_sync (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] d,
  output var  logic [7:0] q
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } bpz_sync_st_t;
  bpz_sync_st_t st_reg;
  bpz_sync_st_t st_next;

  // Shift through two stages
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.s2;
endmodule
`default_nettype wire

// file: bpz_pad_drv.sv
// Pad driver for one 8-bit port: direction, driver type, pull-ups
`timescale 1ns/1ps
`default_nettype none
module bpz_pad_drv (
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         dir_out,
  input  wire logic [7:0]         data,
  input  wire logic               odrain,
  input  wire logic [7:0]         pu_opt,
  output var  bpz_pkg::bpz_pin_drv_t drv
);
  typedef struct packed {
    bpz_pkg::bpz_pin_drv_t d;
  } bpz_pad_st_t;
  bpz_pad_st_t st_reg;
  bpz_pad_st_t st_next;

  // Compute pin drive from direction and driver type
  always_comb begin
    st_next          = st_reg;
    st_next.d.dout   = data;
    st_next.d.oe     = bpz_pkg::drive_oe(dir_out, data, odrain);
    st_next.d.pull_on = pu_opt & ~dir_out;
  end

  // Registered so pin outputs come from flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign drv = st_reg.d;
endmodule
`default_nettype wire

// file: bpz_pin_model.sv
// Model of the outside circuitry on one 8-bit two-way port
`timescale 1ns/1ps
`default_nettype none
module bpz_pin_model (
  input  wire logic       mclk,
  input  wire logic [7:0] dout,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output var  logic [7:0] pin
);
  logic [7:0] last_reg = 8'h00;
  // Port driver wins, then outside driver, then pull-up, else a drifting level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i]) pin[i] = dout[i];
      else if (ext_en[i]) pin[i] = ext_val[i];
      else if (pull_en[i]) pin[i] = 1'b1;
      else pin[i] = ~last_reg[i]; // Undriven line never holds its value
    end
  end
  // Memory of the last level for the floating case
  always @(posedge mclk) begin
    last_reg <= pin;
  end
endmodule
`default_nettype wire

// file: bpz_ports_tb_top.sv
// Self-checking bench for the two bidirectional ports
`timescale 1ns/1ps
`default_nettype none
module bpz_ports_tb_top;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       por_n = 1'b1;
  logic       stop_rec = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata, p0_i, p0_o, p0_oe, p0_pu, p2_i, p2_o, p2_oe, p2_pu;
  logic [7:0] p2_en = 8'h00;
  logic [7:0] p2_val = 8'h00;
  logic       w_and, w_or, edge_in;
  int         fail_count = 0;
  int         num_checks = 0;

  // Clock at 100 MHz
  always #5 mclk = ~mclk;

  bpz_ports #(.P0_PU_OPT(2'b11), .P2_PU_OPT(1'b1)) DUT (
    .mclk(mclk), .rst_n(rst_n), .por_n(por_n), .stop_mode_recovery(stop_rec),
    .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd), .bus_rdata(rdata),
    .first_port_lines_i(p0_i), .first_port_lines_o(p0_o), .first_port_lines_oe(p0_oe),
    .first_port_pullup(p0_pu), .second_port_lines_i(p2_i), .second_port_lines_o(p2_o),
    .second_port_lines_oe(p2_oe), .second_port_pullup(p2_pu),
    .wake_and(w_and), .wake_or(w_or), .edge_detect_in(edge_in));
  bpz_pin_model u_p0 (.mclk(mclk), .dout(p0_o), .oe(p0_oe), .pull_en(p0_pu),
    .ext_en(8'h00), .ext_val(8'h00), .pin(p0_i));
  bpz_pin_model u_p2 (.mclk(mclk), .dout(p2_o), .oe(p2_oe), .pull_en(p2_pu),
    .ext_en(p2_en), .ext_val(p2_val), .pin(p2_i));

  // Comparison with report
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // One-cycle write strobe
  task automatic bus_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic bus_read(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd <= 1'b1; addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Reset state and write-only registers
  task automatic t_reset;
    logic [7:0] d;
    chk("p0_oe", 8'h00, p0_oe);
    chk("p2_oe", 8'h00, p2_oe);
    chk("p0_pu", 8'hFF, p0_pu);
    chk("p2_pu", 8'hFF, p2_pu);
    bus_read(bpz_pkg::ADDR_PORT2_MODE, d);  chk("p2m_rd", 8'h00, d);
    bus_read(bpz_pkg::ADDR_PORT01_MODE, d); chk("port0_1_mode_reg_rd", 8'h00, d);
    bus_read(bpz_pkg::ADDR_PORT_CONFIG, d); chk("port_config_reg_rd", 8'h00, d);
    bus_read(12'h123, d); chk("unmapped_rd", 8'h00, d);
    $display("test reset done");
  endtask
  // Nibble direction, pull-ups off on outputs, driver type
  task automatic t_first;
    logic [7:0] modes [3] = '{8'hCD, 8'h8F, 8'h00};
    logic [7:0] oes [3] = '{8'h0F, 8'hF0, 8'hFF};
    logic [7:0] d;
    bus_write(bpz_pkg::ADDR_PORT0_DATA, 8'hA5);
    settle(2); chk("p0_oe_nomode", 8'h00, p0_oe);
    for (int i = 0; i < 3; i++) begin
      bus_write(bpz_pkg::ADDR_PORT01_MODE, modes[i]);
      settle(1); chk("p0_oe", oes[i], p0_oe);
      chk("p0_o", 8'hA5 & oes[i], p0_o & oes[i]);
      chk("p0_pu", ~oes[i], p0_pu);
    end
    bus_write(bpz_pkg::ADDR_PORT_CONFIG, 8'h04);
    settle(1); chk("p0_oe_od", 8'h5A, p0_oe);
    bus_write(bpz_pkg::ADDR_PORT_CONFIG, 8'h00);
    settle(1); chk("p0_oe_pp", 8'hFF, p0_oe);
    settle(2);
    bus_read(bpz_pkg::ADDR_PORT0_DATA, d); chk("p0_rd", 8'hA5, d);
    $display("test first port done");
  endtask
  // Stop recovery returns first port to input
  task automatic t_stop;
    @(posedge mclk);
    stop_rec <= 1'b1;
    @(posedge mclk);
    stop_rec <= 1'b0;
    for (int i = 0; i < 10 && p0_oe !== 8'h00; i++) settle(1);
    chk("p0_oe_smr", 8'h00, p0_oe);
    chk("p0_pu_smr", 8'hFF, p0_pu);
    $display("test stop recovery done");
  endtask
  // Per-bit direction and shared driver type
  task automatic t_second;
    bus_write(bpz_pkg::ADDR_PORT2_DATA, 8'h0F);
    bus_write(bpz_pkg::ADDR_PORT2_MODE, 8'h5A);
    settle(1); chk("p2_oe", 8'hA5, p2_oe);
    chk("p2_pu", 8'h5A, p2_pu);
    chk("p2_o", 8'h0F, p2_o);
    bus_write(bpz_pkg::ADDR_WAKE_CTRL, 8'h01);
    settle(1); chk("p2_oe_od", 8'hA0, p2_oe);
    $display("test second port done");
  endtask
  // Wake gates, edge tap and input reads
  task automatic t_wake;
    logic [7:0] v [4] = '{8'hFF, 8'h00, 8'hFE, 8'h01};
    logic [7:0] d;
    bus_write(bpz_pkg::ADDR_PORT2_MODE, 8'hFF);
    bus_write(bpz_pkg::ADDR_WAKE_CTRL, 8'h06);
    p2_en <= 8'hFF;
    for (int i = 0; i < 4; i++) begin
      p2_val <= v[i];
      settle(5);
      chk("wake_and", {7'h00, &v[i]}, {7'h00, w_and});
      chk("wake_or", {7'h00, |v[i]}, {7'h00, w_or});
      chk("edge_in", {7'h00, v[i][0]}, {7'h00, edge_in});
      bus_read(bpz_pkg::ADDR_PORT2_DATA, d); chk("p2_rd", v[i], d);
    end
    bus_write(bpz_pkg::ADDR_WAKE_CTRL, 8'h02);
    settle(2); chk("edge_off", 8'h00, {7'h00, edge_in});
    bus_write(bpz_pkg::ADDR_WAKE_CTRL, 8'h04);
    settle(2); chk("edge_nodemod", 8'h00, {7'h00, edge_in});
    p2_en <= 8'h00;
    $display("test wake done");
  endtask
  // Power-on reset makes both ports input
  task automatic t_por;
    bus_write(bpz_pkg::ADDR_PORT01_MODE, 8'h00);
    bus_write(bpz_pkg::ADDR_PORT2_MODE, 8'h00);
    settle(1); chk("p2_oe_pre", 8'hFF, p2_oe);
    @(posedge mclk); por_n <= 1'b0;
    repeat (3) @(posedge mclk);
    por_n <= 1'b1;
    for (int i = 0; i < 10 && p2_oe !== 8'h00; i++) settle(1);
    chk("p2_oe_por", 8'h00, p2_oe);
    chk("p0_oe_por", 8'h00, p0_oe);
    $display("test power-on reset done");
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    settle(3);
    t_reset();
    t_first();
    t_stop();
    t_second();
    t_wake();
    t_por();
    stop_test();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
